/* File: hdl/pcd_divider_chain.sv */
// Top of the loop divider chain: bus registers, pre-scale, feedback, halving, outputs.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module pcd_divider_chain
   import pcd_pkg::*;
#(
   parameter int NUM_OUT = PCD_NUM_OUT
) (
   input  wire logic                 I_CLK,
   input  wire logic                 I_RST_N,
   input  wire logic                 I_REF,
   input  wire logic                 I_LOOP_RESET,
   input  wire logic                 I_WB_CYC,
   input  wire logic                 I_WB_STB,
   input  wire logic                 I_WB_WE,
   input  wire logic [PCD_ADR_W-1:0] I_WB_ADR,
   input  wire logic [3:0]           I_WB_SEL,
   input  wire logic [31:0]          I_WB_DAT,
   output logic      [31:0]          O_WB_DAT,
   output logic                      O_WB_ACK,
   output logic                      O_REF_DIV,
   output logic                      O_FB_CLK,
   output logic                      O_IN_RESET,
   output logic      [NUM_OUT-1:0]   O_CLK_OUT
);
   // Software-side settings, written at any time.
   logic [31:0] ctrl_q, ctrl_d, pre_q, pre_d, mul_q, mul_d, frac_q, frac_d;
   logic [31:0] out_q [NUM_OUT];
   logic [31:0] out_d [NUM_OUT];
   logic        ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;

   // Settings the counters actually use.
   logic [31:0] a_ctrl_q, a_ctrl_d, a_pre_q, a_pre_d, a_mul_q, a_mul_d, a_frac_q, a_frac_d;
   logic [31:0] a_out_q [NUM_OUT];
   logic [31:0] a_out_d [NUM_OUT];

   logic [2:0]  ref_sync_q, ref_sync_d;
   logic        ref_lvl_q, ref_lvl_d;
   logic [2:0]  lrst_sync_q, lrst_sync_d;
   logic        lrst_lvl_q, lrst_lvl_d;
   logic        loop_rst_q, loop_rst_d;
   logic        halve_q, halve_d;
   logic [32:0] acc_q, acc_d;
   logic        ext_q, ext_d;

   logic        ref_rise, post_tick, m_wrap, n_level, m_level;
   logic        req, wr;
   logic [31:0] wmask;
   logic [32:0] sum;
   logic        carry;
   logic [NUM_OUT-1:0] c_level;

   // Pin synchronisers: the first stage feeds only the second.
   always_comb begin
      ref_sync_d  = {ref_sync_q[1:0], I_REF};
      lrst_sync_d = {lrst_sync_q[1:0], I_LOOP_RESET};
      ref_lvl_d   = (ref_sync_q[1] == ref_sync_q[2]) ? ref_sync_q[2] : ref_lvl_q;
      lrst_lvl_d  = (lrst_sync_q[1] == lrst_sync_q[2]) ? lrst_sync_q[2] : lrst_lvl_q;
      ref_rise    = ref_lvl_d & ~ref_lvl_q;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         ref_sync_q  <= 3'h0;
         lrst_sync_q <= 3'h0;
         ref_lvl_q   <= 1'b0;
         lrst_lvl_q  <= 1'b0;
      end else begin
         ref_sync_q  <= ref_sync_d;
         lrst_sync_q <= lrst_sync_d;
         ref_lvl_q   <= ref_lvl_d;
         lrst_lvl_q  <= lrst_lvl_d;
      end
   end

   // Wishbone slave: every access is acked one cycle after it is seen.
   always_comb begin
      req   = I_WB_CYC & I_WB_STB & ~ack_q;
      wr    = req & I_WB_WE;
      wmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
      ack_d  = req;
      ctrl_d = ctrl_q;
      pre_d  = pre_q;
      mul_d  = mul_q;
      frac_d = frac_q;
      rdat_d = 32'h0000_0000;
      for (int i = 0; i < NUM_OUT; i++) begin
         out_d[i] = out_q[i];
      end
      if (I_WB_ADR == PCD_ADR_CTRL) begin
         rdat_d = ctrl_q;
         if (wr) ctrl_d = (ctrl_q & ~wmask) | (I_WB_DAT & wmask);
      end else if (I_WB_ADR == PCD_ADR_PRE) begin
         rdat_d = pre_q;
         if (wr) pre_d = (pre_q & ~wmask) | (I_WB_DAT & wmask);
      end else if (I_WB_ADR == PCD_ADR_MUL) begin
         rdat_d = mul_q;
         if (wr) mul_d = (mul_q & ~wmask) | (I_WB_DAT & wmask);
      end else if (I_WB_ADR == PCD_ADR_FRAC) begin
         rdat_d = frac_q;
         if (wr) frac_d = (frac_q & ~wmask) | (I_WB_DAT & wmask);
      end else if (I_WB_ADR == PCD_ADR_STATUS) begin
         rdat_d = {28'h000_0000 | 28'(c_level), 1'b0, m_level, n_level, loop_rst_q};
      end else begin
         for (int i = 0; i < NUM_OUT; i++) begin
            if (I_WB_ADR == PCD_ADR_OUT0 + 8'(4 * i)) begin
               rdat_d = out_q[i];
               if (wr) out_d[i] = (out_q[i] & ~wmask) | (I_WB_DAT & wmask);
            end
         end
      end
      // Field widths are fixed by the bit layout; unused bits read as zero.
      ctrl_d = ctrl_d & 32'h0000_0037;
      pre_d  = pre_d & 32'h01FF_01FF;
      mul_d  = mul_d & 32'h01FF_01FF;
      for (int i = 0; i < NUM_OUT; i++) begin
         out_d[i] = out_d[i] & 32'h01FF_01FF;
      end
      if (!req || I_WB_WE) rdat_d = 32'h0000_0000;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
         ctrl_q <= PCD_CTRL_RESET;
         pre_q  <= PCD_CNT_RESET;
         mul_q  <= PCD_CNT_RESET;
         frac_q <= PCD_FRAC_RESET;
         for (int i = 0; i < NUM_OUT; i++) out_q[i] <= PCD_CNT_RESET;
      end else begin
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
         ctrl_q <= ctrl_d;
         pre_q  <= pre_d;
         mul_q  <= mul_d;
         frac_q <= frac_d;
         for (int i = 0; i < NUM_OUT; i++) out_q[i] <= out_d[i];
      end
   end

   // Loop reset and setting transfer. Settings move into the counters only while
   // the loop is held, so a rewrite can never cut a phase short mid-period.
   always_comb begin
      loop_rst_d = ctrl_q[PCD_CTRL_RST] | lrst_lvl_q;
      a_ctrl_d = a_ctrl_q;
      a_pre_d  = a_pre_q;
      a_mul_d  = a_mul_q;
      a_frac_d = a_frac_q;
      for (int i = 0; i < NUM_OUT; i++) a_out_d[i] = a_out_q[i];
      if (loop_rst_q) begin
         a_ctrl_d = ctrl_q;
         a_pre_d  = pre_q;
         a_mul_d  = mul_q;
         a_frac_d = frac_q;
         for (int i = 0; i < NUM_OUT; i++) a_out_d[i] = out_q[i];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         loop_rst_q <= 1'b1;
         a_ctrl_q   <= PCD_CTRL_RESET;
         a_pre_q    <= PCD_CNT_RESET;
         a_mul_q    <= PCD_CNT_RESET;
         a_frac_q   <= PCD_FRAC_RESET;
         for (int i = 0; i < NUM_OUT; i++) a_out_q[i] <= PCD_CNT_RESET;
      end else begin
         loop_rst_q <= loop_rst_d;
         a_ctrl_q   <= a_ctrl_d;
         a_pre_q    <= a_pre_d;
         a_mul_q    <= a_mul_d;
         a_frac_q   <= a_frac_d;
         for (int i = 0; i < NUM_OUT; i++) a_out_q[i] <= a_out_d[i];
      end
   end

   // Fraction modulator: first-order accumulator whose carry lengthens the next
   // feedback period by one count. Cheap, at the price of periodic spurs.
   always_comb begin
      sum   = acc_q + {1'b0, a_frac_q};
      carry = 1'b0;
      case (a_ctrl_q[PCD_CTRL_WID_LO +: 2])
         PCD_WID_8: begin
            sum   = {25'h000_0000, acc_q[7:0]} + {25'h000_0000, a_frac_q[7:0]};
            carry = sum[8];
            sum   = sum & 33'h0_0000_00FF;
         end
         PCD_WID_16: begin
            sum   = {17'h0_0000, acc_q[15:0]} + {17'h0_0000, a_frac_q[15:0]};
            carry = sum[16];
            sum   = sum & 33'h0_0000_FFFF;
         end
         PCD_WID_24: begin
            sum   = {9'h000, acc_q[23:0]} + {9'h000, a_frac_q[23:0]};
            carry = sum[24];
            sum   = sum & 33'h0_00FF_FFFF;
         end
         default: begin
            carry = sum[32];
            sum   = sum & 33'h0_FFFF_FFFF;
         end
      endcase
      acc_d = acc_q;
      ext_d = ext_q;
      if (loop_rst_q || !a_ctrl_q[PCD_CTRL_FRAC]) begin
         acc_d = 33'h0_0000_0000;
         ext_d = 1'b0;
      end else if (m_wrap) begin
         acc_d = sum;
         ext_d = carry;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         acc_q <= 33'h0_0000_0000;
         ext_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         ext_q <= ext_d;
      end
   end

   // Halving stage: the oscillator tick is every clock cycle.
   always_comb begin
      halve_d   = loop_rst_q ? 1'b0 : ~halve_q;
      post_tick = a_ctrl_q[PCD_CTRL_HALVE] ? halve_q : 1'b1;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) halve_q <= 1'b0;
      else halve_q <= halve_d;
   end

   // Pre-scale divides the reference edges; its level follows its own high and low counts.
   // The analogue loop outside closes on the ratio of feedback to pre-scale.
   pcd_phase_counter #(.W(PCD_CNT_W)) u_pre (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_clr   (loop_rst_q),
      .i_en    (ref_rise),
      .i_hi    (a_pre_q[PCD_HI_LSB +: PCD_CNT_W]),
      .i_lo    (a_pre_q[PCD_LO_LSB +: PCD_CNT_W]),
      .i_ext   (1'b0),
      .o_level (n_level),
      .o_wrap  ()
   );

   pcd_phase_counter #(.W(PCD_CNT_W)) u_mul (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_clr   (loop_rst_q),
      .i_en    (1'b1),
      .i_hi    (a_mul_q[PCD_HI_LSB +: PCD_CNT_W]),
      .i_lo    (a_mul_q[PCD_LO_LSB +: PCD_CNT_W]),
      .i_ext   (ext_q),
      .o_level (m_level),
      .o_wrap  (m_wrap)
   );

   // Equal high and low counts give the even-split waveform.
   for (genvar g = 0; g < NUM_OUT; g++) begin : g_post
      pcd_phase_counter #(.W(PCD_CNT_W)) u_post (
         .i_clk   (I_CLK),
         .i_rst_n (I_RST_N),
         .i_clr   (loop_rst_q),
         .i_en    (post_tick),
         .i_hi    (a_out_q[g][PCD_HI_LSB +: PCD_CNT_W]),
         .i_lo    (a_out_q[g][PCD_LO_LSB +: PCD_CNT_W]),
         .i_ext   (1'b0),
         .o_level (c_level[g]),
         .o_wrap  ()
      );
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_REF_DIV  <= 1'b0;
         O_FB_CLK   <= 1'b0;
         O_IN_RESET <= 1'b1;
         O_CLK_OUT  <= '0;
      end else begin
         O_REF_DIV  <= n_level;
         O_FB_CLK   <= m_level;
         O_IN_RESET <= loop_rst_q;
         O_CLK_OUT  <= c_level;
      end
   end

   assign O_WB_ACK = ack_q;
   assign O_WB_DAT = rdat_q;
endmodule : pcd_divider_chain

/* File: hdl/pcd_pkg.sv */
// Shared constants for the loop divider chain: register map, fields, reset values.
// What this block does
// - Pre-scale and feedback divides span 2 to 1022.
// - Separate high and low counts, each 1-511.
// - Divide ratio equals high plus low count.
// - Pre-scale counter divides with its own high and low counts, so it shapes duty too.
// - Post-scale counters offer an even-split waveform.
// - Halving stage divides by two or bypasses.
// - Each output has its own post-scale counter.
// - Oscillator runs at input times feedback over pre-scale.
// - Modulator varies feedback divide cycle by cycle.
// - Fractional divide is high plus low plus fraction.
// - Fraction is numerator over two to width.
// - Integer mode: whole divide, modulator disabled.
// - Feedback counter output drives feedback clock pin.
// - Loop reset holds counters and clears outputs.
package pcd_pkg;
   localparam int          PCD_CNT_W       = 9;
   localparam int          PCD_ADR_W       = 8;
   localparam int          PCD_NUM_OUT     = 4;
   localparam logic [7:0]  PCD_ADR_CTRL    = 8'h00;
   localparam logic [7:0]  PCD_ADR_PRE     = 8'h04;
   localparam logic [7:0]  PCD_ADR_MUL     = 8'h08;
   localparam logic [7:0]  PCD_ADR_FRAC    = 8'h0C;
   localparam logic [7:0]  PCD_ADR_STATUS  = 8'h10;
   localparam logic [7:0]  PCD_ADR_OUT0    = 8'h20;
   localparam int          PCD_CTRL_RST    = 0;
   localparam int          PCD_CTRL_FRAC   = 1;
   localparam int          PCD_CTRL_HALVE  = 2;
   localparam int          PCD_CTRL_WID_LO = 4;
   localparam int          PCD_HI_LSB      = 0;
   localparam int          PCD_LO_LSB      = 16;
   localparam logic [31:0] PCD_CTRL_RESET  = 32'h0000_0001;
   localparam logic [31:0] PCD_CNT_RESET   = 32'h0001_0001;
   localparam logic [31:0] PCD_FRAC_RESET  = 32'h0000_0000;
   localparam logic [1:0]  PCD_WID_8       = 2'h0;
   localparam logic [1:0]  PCD_WID_16      = 2'h1;
   localparam logic [1:0]  PCD_WID_24      = 2'h2;
   localparam logic [1:0]  PCD_WID_32      = 2'h3;
endpackage : pcd_pkg

/* File: hdl/pcd_phase_counter.sv */
// One high/low phase divider stepped by a clock enable.
`timescale 1ns/1ps
module pcd_phase_counter
   import pcd_pkg::*;
#(
   parameter int W = PCD_CNT_W
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_clr,
   input  wire logic         i_en,
   input  wire logic [W-1:0] i_hi,
   input  wire logic [W-1:0] i_lo,
   input  wire logic         i_ext,
   output logic              o_level,
   output logic              o_wrap
);
   logic [W:0] cnt_q, cnt_d;
   logic       level_q, level_d;
   logic       wrap_q, wrap_d;
   logic [W:0] hi_lim, lo_lim;

   always_comb begin
      // A zero count is illegal; it is run as one so the counter never stalls.
      hi_lim = (i_hi == '0) ? (W+1)'(1) : {1'b0, i_hi};
      lo_lim = ((i_lo == '0) ? (W+1)'(1) : {1'b0, i_lo}) + (W+1)'(i_ext);
      cnt_d   = cnt_q;
      level_d = level_q;
      wrap_d  = 1'b0;
      if (i_clr) begin
         cnt_d   = '0;
         level_d = 1'b0;
      end else if (i_en) begin
         cnt_d = cnt_q + (W+1)'(1);
         if (level_q && cnt_d >= hi_lim) begin
            level_d = 1'b0;
            cnt_d   = '0;
         end else if (!level_q && cnt_d >= lo_lim) begin
            level_d = 1'b1;
            cnt_d   = '0;
            wrap_d  = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_q   <= '0;
         level_q <= 1'b0;
         wrap_q  <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         level_q <= level_d;
         wrap_q  <= wrap_d;
      end
   end

   assign o_level = level_q;
   assign o_wrap  = wrap_q;
endmodule : pcd_phase_counter

/* File: sim/pcd_chain_properties.sv */
// Checker for bus handshake, loop hold and feedback phase lengths.
`timescale 1ns/1ps
module pcd_chain_properties
   import pcd_pkg::*;
#(
   parameter int NUM_OUT = PCD_NUM_OUT
) (
   input wire logic                 I_CLK,
   input wire logic                 I_RST_N,
   input wire logic                 I_LOOP_RESET,
   input wire logic                 I_WB_CYC,
   input wire logic                 I_WB_STB,
   input wire logic                 I_WB_WE,
   input wire logic [PCD_ADR_W-1:0] I_WB_ADR,
   input wire logic [3:0]           I_WB_SEL,
   input wire logic [31:0]          I_WB_DAT,
   input wire logic [31:0]          O_WB_DAT,
   input wire logic                 O_WB_ACK,
   input wire logic                 O_REF_DIV,
   input wire logic                 O_FB_CLK,
   input wire logic                 O_IN_RESET,
   input wire logic [NUM_OUT-1:0]   O_CLK_OUT
);
   logic [8:0] hi_q, lo_q, ahi_q, alo_q;
   logic       fr_q, afr_q, p_q, seen_q;
   logic [9:0] run_q;
   wire        wr = I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK && I_WB_SEL == 4'hF;
   // Shadows follow the settings the counters should use: taken only while held.
   always_ff @(posedge I_CLK) begin
      p_q <= O_FB_CLK;
      run_q <= (O_FB_CLK != p_q) ? 10'd1 : run_q + 10'd1;
      seen_q <= O_IN_RESET ? 1'b0 : (seen_q || (p_q && !O_FB_CLK));
      if (!I_RST_N) begin
         hi_q <= 9'd1;
         lo_q <= 9'd1;
         fr_q <= 1'b0;
      end else if (wr && I_WB_ADR == PCD_ADR_MUL) begin
         hi_q <= I_WB_DAT[8:0];
         lo_q <= I_WB_DAT[24:16];
      end else if (wr && I_WB_ADR == PCD_ADR_CTRL) begin
         fr_q <= I_WB_DAT[PCD_CTRL_FRAC];
      end
      if (O_IN_RESET) begin
         ahi_q <= hi_q;
         alo_q <= lo_q;
         afr_q <= fr_q;
      end
   end
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   sequence req_s;
      I_WB_CYC && I_WB_STB && !O_WB_ACK;
   endsequence
   sequence fell_s;
      !O_FB_CLK && p_q && !O_IN_RESET;
   endsequence
   sequence rose_s;
      O_FB_CLK && !p_q && seen_q;
   endsequence
   ack_next_a: assert property (req_s |=> O_WB_ACK) else $error("ack missing");
   ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
   idle_data_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0000_0000)
      else $error("data without ack");
   held_clear_a: assert property (O_IN_RESET && $past(O_IN_RESET) |->
      !O_FB_CLK && !O_REF_DIV && O_CLK_OUT == '0) else $error("output while held");
   pin_hold_a: assert property (I_LOOP_RESET [*8] |-> O_IN_RESET)
      else $error("pin reset not held");
   ctrl_hold_a: assert property (wr && I_WB_ADR == PCD_ADR_CTRL && I_WB_DAT[0]
      |-> ##[1:4] O_IN_RESET) else $error("control reset not held");
   fb_high_a: assert property (fell_s |-> run_q == {1'b0, ahi_q})
      else $error("feedback high length");
   fb_low_a: assert property (rose_s |-> run_q == {1'b0, alo_q} ||
      (afr_q && run_q == {1'b0, alo_q} + 10'd1)) else $error("feedback low length");
endmodule : pcd_chain_properties
bind pcd_divider_chain pcd_chain_properties #(.NUM_OUT(NUM_OUT)) i_props (.I_CLK, .I_RST_N,
   .I_LOOP_RESET, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT,
   .O_WB_DAT, .O_WB_ACK, .O_REF_DIV, .O_FB_CLK, .O_IN_RESET, .O_CLK_OUT);

/* File: sim/pcd_clk_meter.sv */
// Consumer-side model that times the high and low phases of one clock.
`timescale 1ns/1ps
module pcd_clk_meter (
   input  wire logic i_clk,
   input  wire logic i_clr,
   input  wire logic i_lvl,
   output int        o_hi,
   output int        o_lo,
   output int        o_n,
   output int        o_ls
);
   logic p_q = 1'b0;
   logic s_q = 1'b0;
   int   r_q = 0;
   // A phase counts only after one edge was seen, so a partial phase is never timed.
   always_ff @(posedge i_clk) begin
      p_q <= i_lvl;
      r_q <= (i_lvl != p_q) ? 1 : r_q + 1;
      if (i_clr) begin
         s_q <= 1'b0;
         o_n <= 0;
         o_ls <= 0;
      end else if (i_lvl != p_q) begin
         s_q <= 1'b1;
         if (s_q && !i_lvl) o_hi <= r_q;
         if (s_q && i_lvl && o_n < 16) begin
            o_lo <= r_q;
            o_n <= o_n + 1;
            o_ls <= o_ls + r_q;
         end
      end
   end
endmodule : pcd_clk_meter

/* File: sim/pcd_divider_chain_tb.sv */
// Self-checking bench for the loop divider chain.
`timescale 1ns/1ps
module pcd_divider_chain_tb;
   import pcd_pkg::*;
   logic        clk, rst_n, rf, lr, cyc, stb, we, mclr, ack, fbc, rdv, inr;
   logic [7:0]  adr;
   logic [3:0]  sel, co;
   logic [31:0] dw, dr;
   logic [31:0] mdl [int];
   int          fails, n_checks, tmo, rc;
   int          m_hi[6], m_lo[6], m_n[6], m_ls[6];
   logic [7:0]  adrs[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28, 8'h2C,
                             8'h40, 8'h14};
   pcd_divider_chain i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_REF(rf), .I_LOOP_RESET(lr),
      .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
      .I_WB_DAT(dw), .O_WB_DAT(dr), .O_WB_ACK(ack), .O_REF_DIV(rdv), .O_FB_CLK(fbc),
      .O_IN_RESET(inr), .O_CLK_OUT(co));
   wire [5:0]   lvl = {co, fbc, rdv};
   for (genvar g = 0; g < 6; g++) begin : g_mon
      pcd_clk_meter i_mon (.i_clk(clk), .i_clr(mclr), .i_lvl(lvl[g]), .o_hi(m_hi[g]),
         .o_lo(m_lo[g]), .o_n(m_n[g]), .o_ls(m_ls[g]));
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Reference runs at a quarter of the clock rate.
   always @(posedge clk) begin
      rc <= rc + 1;
      if (rc[0]) rf <= ~rf;
      tmo <= tmo + 1;
      if (tmo == 40000) begin
         fails++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   function automatic logic [31:0] msk(input logic [7:0] a);
      return a == PCD_ADR_CTRL ? 32'h0000_0037 : a == PCD_ADR_FRAC ? 32'hFFFF_FFFF :
         32'h01FF_01FF;
   endfunction : msk
   function automatic logic [31:0] cnt(input int h, input int l);
      return {7'h00, 9'(l), 7'h00, 9'(h)};
   endfunction : cnt
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      sel <= s;
      do @(posedge clk); while (ack !== 1'b1);
      q = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      logic [31:0] q, m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & msk(a);
      bus(a, 1'b1, d, s, q);
      if (mdl.exists(a)) mdl[a] = (mdl[a] & ~m) | (d & m);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0000_0000, 4'hF, q);
      chk(q, mdl.exists(a) ? mdl[a] : 32'h0000_0000);
   endtask : rd
   task automatic run(input bit h, input bit f, input logic [1:0] w, input int ph,
                      input int pl, input int mh, input int ml);
      int          oh[4];
      logic [31:0] q;
      wr(PCD_ADR_CTRL, 32'h0000_0001);
      wr(PCD_ADR_PRE, cnt(ph, pl));
      wr(PCD_ADR_MUL, cnt(mh, ml));
      for (int i = 0; i < 4; i++) begin
         oh[i] = 1 + $urandom % 6;
         wr(PCD_ADR_OUT0 + 8'(4 * i), cnt(oh[i], i == 0 ? oh[i] : 7 - oh[i]));
      end
      mclr <= 1'b1;
      @(posedge clk);
      mclr <= 1'b0;
      wr(PCD_ADR_CTRL, {26'h0, w, 1'b0, h, f, 1'b0});
      while (m_n[1] < 16 || m_n[0] < 1 || m_n[2] < 1 || m_n[3] < 1 || m_n[4] < 1 ||
             m_n[5] < 1) @(posedge clk);
      chk(m_hi[1], mh);
      chk(m_ls[1], 16 * ml + (f ? 4 : 0));
      chk(m_hi[0], 4 * ph);
      chk(m_lo[0], 4 * pl);
      for (int i = 0; i < 4; i++) begin
         chk(m_hi[2 + i], oh[i] * (h ? 2 : 1));
         chk(m_lo[2 + i], (i == 0 ? oh[i] : 7 - oh[i]) * (h ? 2 : 1));
      end
      // A new feedback setting must wait for the next hold before it is used.
      wr(PCD_ADR_MUL, cnt(mh % 8 + 1, ml));
      repeat (40) @(posedge clk);
      chk(m_hi[1], mh);
      lr <= 1'b1;
      repeat (10) @(posedge clk);
      chk(inr, 1'b1);
      chk({co, fbc, rdv}, 32'h0000_0000);
      bus(PCD_ADR_STATUS, 1'b0, 32'h0000_0000, 4'hF, q);
      chk(q[0], 1'b1);
      lr <= 1'b0;
      repeat (10) @(posedge clk);
      chk(inr, 1'b0);
      rd(PCD_ADR_MUL);
   endtask : run
   initial begin
      {rst_n, rf, lr, cyc, stb, we, mclr, adr, sel, dw} = '0;
      {fails, n_checks, tmo, rc} = '0;
      mdl[PCD_ADR_CTRL] = PCD_CTRL_RESET;
      mdl[PCD_ADR_PRE] = PCD_CNT_RESET;
      mdl[PCD_ADR_MUL] = PCD_CNT_RESET;
      mdl[PCD_ADR_FRAC] = PCD_FRAC_RESET;
      for (int i = 0; i < 4; i++) mdl[PCD_ADR_OUT0 + 8'(4 * i)] = PCD_CNT_RESET;
      void'($urandom(32'hef66aff2));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 9; i++) rd(adrs[i]);
      for (int i = 0; i < 10; i++) begin
         wr(adrs[i], 32'hFFFF_FFFF);
         if (i < 9) rd(adrs[i]);
      end
      wr(PCD_ADR_FRAC, $urandom, 4'h2);
      rd(PCD_ADR_FRAC);
      run(1'b0, 1'b0, 2'h0, 1, 1, 1, 1);
      run(1'b0, 1'b0, 2'h0, 2, 3, 1 + $urandom % 8, 1 + $urandom % 8);
      run(1'b1, 1'b0, 2'h0, 3, 2, 1 + $urandom % 8, 1 + $urandom % 8);
      // Each width gets a numerator of one quarter, so every fourth period stretches.
      for (int w = 0; w < 4; w++) begin
         wr(PCD_ADR_FRAC, 32'h0000_0001 << (8 * w + 6));
         run(1'b0, 1'b1, w[1:0], 2, 2, 1 + $urandom % 8, 1 + $urandom % 8);
      end
      run(1'b0, 1'b0, 2'h0, 2, 2, 1 + $urandom % 8, 1 + $urandom % 8);
      run(1'b1, 1'b0, 2'h0, 256, 256, 256, 256);
      complete_run();
   end
endmodule : pcd_divider_chain_tb
